// ==== dv/pdl_divider_lock_chk.sv ====
// Assertion checker for the divider path and lock block
`timescale 1ns/1ps
`default_nettype none
module pdl_divider_lock_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire pdl_pkg::pdl_bus_t busReq,
  input wire logic [31:0] busRdata,
  // Loop side
  input wire logic reference_clock_in,
  input wire logic fbClkIn,
  input wire logic calStart,
  input wire logic calDone,
  input wire logic calBypass,
  input wire logic vtuneInRange,
  // Pump and lock
  input wire logic pumpUp,
  input wire logic pumpDown,
  input wire logic [3:0] pumpCurrent,
  input wire logic lock_indicator
);
  logic vtEn_r;
  logic [3:0] cp_r;
  // Shadow of the control fields that lock and pump outputs depend on
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vtEn_r <= 1'b0;
      cp_r <= 4'h0;
    end else if (busReq.wr && busReq.addr == pdl_pkg::OFF_CTRL) begin
      vtEn_r <= busReq.wdata[pdl_pkg::CB_VTEN];
      cp_r <= busReq.wdata[pdl_pkg::CB_CP +: 4];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_calLow;
    (calStart && !calBypass) ##1 (!calDone && !calBypass) [*2] |-> !lock_indicator;
  endproperty
  a_calLow: assert property (p_calLow) else $error("lock high during calibration");
  property p_bypass;
    calBypass |=> lock_indicator == $past(vtuneInRange);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass lock not tuning only");
  property p_vtLow;
    !calBypass && vtEn_r && !vtuneInRange |=> !lock_indicator;
  endproperty
  a_vtLow: assert property (p_vtLow) else $error("lock high with tuning out");
  property p_pumpCur;
    (pumpUp || pumpDown) |-> pumpCurrent == $past(cp_r);
  endproperty
  a_pumpCur: assert property (p_pumpCur) else $error("pump current wrong");
  property p_pumpIdle;
    !(pumpUp || pumpDown) |-> pumpCurrent == 4'h0;
  endproperty
  a_pumpIdle: assert property (p_pumpIdle) else $error("pump current while idle");
  property p_rdIdle;
    !busReq.rd |=> busRdata == 32'h0000_0000;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
  property p_unmapped;
    busReq.rd && busReq.addr == 8'h24 |=> busRdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_statusLock;
    busReq.rd && busReq.addr == pdl_pkg::OFF_STATUS |=>
      busRdata[pdl_pkg::SB_LOCK] == $past(lock_indicator);
  endproperty
  a_statusLock: assert property (p_statusLock) else $error("status lock mismatch");
endmodule
bind pdl_divider_lock pdl_divider_lock_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .busReq(busReq), .busRdata(busRdata), .reference_clock_in(reference_clock_in),
  .fbClkIn(fbClkIn), .calStart(calStart), .calDone(calDone), .calBypass(calBypass),
  .vtuneInRange(vtuneInRange), .pumpUp(pumpUp), .pumpDown(pumpDown),
  .pumpCurrent(pumpCurrent), .lock_indicator(lock_indicator));
`default_nettype wire

// ==== dv/tb_pdl_divider_lock.sv ====
// Self-checking bench for the divider path and lock block
`timescale 1ns/1ps
`default_nettype none
module tb_pdl_divider_lock;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } pdl_row_t;
  logic core_clk, rst_n, refClk, fbClk, calStart, calDone, calBypass, vtune;
  logic pumpUp, pumpDown, lockOut;
  logic [3:0] pumpCurrent;
  logic [31:0] busRdata, rdVal;
  pdl_pkg::pdl_bus_t busReq;
  int miscompares, nChecks;
  pdl_row_t rows [12];
  pdl_divider_lock dut_u (.core_clk(core_clk), .rst_n(rst_n), .busReq(busReq),
    .busRdata(busRdata), .reference_clock_in(refClk), .fbClkIn(fbClk), .calStart(calStart),
    .calDone(calDone), .calBypass(calBypass), .vtuneInRange(vtune), .pumpUp(pumpUp),
    .pumpDown(pumpDown), .pumpCurrent(pumpCurrent), .lock_indicator(lockOut));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Ends a little after an edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1 d = busRdata;
  endtask
  task automatic cal(input logic st);
    @(posedge core_clk);
    if (st) calStart <= 1'b1;
    else calDone <= 1'b1;
    @(posedge core_clk);
    calStart <= 1'b0;
    calDone <= 1'b0;
  endtask
  // Reference toggles every two cycles, well inside the sampling limit
  task automatic tog(input int n);
    repeat (n) begin
      @(posedge core_clk);
      refClk <= !refClk;
      @(posedge core_clk);
    end
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  // Lock delay of 1 needs four detector events; a doubler makes one per reference edge
  task automatic lock_run(input logic dbl);
    int e;
    e = dbl ? 1 : 2;
    wr_reg(pdl_pkg::OFF_CTRL, 32'h0000_020C | 32'(dbl));
    wr_reg(pdl_pkg::OFF_LDLY, 32'h0000_0001);
    cal(1'b1);
    cyc(3);
    chk("lock in cal", {31'h0, lockOut}, 32'h0);
    cal(1'b0);
    tog(2 * e);
    cyc(4);
    cal(1'b1);
    cal(1'b0);
    tog(3 * e);
    cyc(6);
    chk("lock early", {31'h0, lockOut}, 32'h0);
    tog(e);
    cyc(8);
    chk("lock late", {31'h0, lockOut}, 32'h1);
    $display("lock run dbl=%0d done", dbl);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Whole run is near 430 cycles; this allows a wide margin
  initial begin
    #2_000_000;
    miscompares++;
    stop_test;
  end
  initial begin
    {rst_n, refClk, fbClk, calStart, calDone, calBypass} = '0;
    vtune = 1'b1;
    busReq = '0;
    miscompares = 0;
    nChecks = 0;
    rows[0] = '{pdl_pkg::OFF_CTRL, 1'b0, 32'h0, 32'h0000_000C};
    rows[1] = '{pdl_pkg::OFF_PREDIV, 1'b0, 32'h0, 32'h0000_0001};
    rows[2] = '{pdl_pkg::OFF_POSTDIV, 1'b0, 32'h0, 32'h0000_0001};
    rows[3] = '{pdl_pkg::OFF_NINT, 1'b0, 32'h0, 32'h0000_000C};
    rows[4] = '{pdl_pkg::OFF_DEN, 1'b0, 32'h0, 32'h0000_0001};
    rows[5] = '{pdl_pkg::OFF_STATUS, 1'b1, 32'hFFFF_FFFF, 32'h0000_0005};
    rows[6] = '{pdl_pkg::OFF_PREDIV, 1'b1, 32'h0000_FFFF, 32'h0000_0FFF};
    rows[7] = '{pdl_pkg::OFF_NINT, 1'b1, 32'h0000_FFFF, 32'h0000_7FFF};
    rows[8] = '{pdl_pkg::OFF_DEN, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
    rows[9] = '{8'h24, 1'b1, 32'h0000_0055, 32'h0};
    rows[10] = '{pdl_pkg::OFF_CTRL, 1'b1, 32'h0000_F3FC, 32'h0000_F3FC};
    rows[11] = '{pdl_pkg::OFF_CTRL, 1'b1, 32'h0000_0008, 32'h0000_001C};
    do_reset;
    cyc(4);
    foreach (rows[i]) begin
      if (rows[i].wr) wr_reg(rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].addr, rdVal);
      chk("reg", rdVal, rows[i].exp);
    end
    $display("register table done");
    do_reset;
    lock_run(1'b0);
    lock_run(1'b1);
    @(posedge core_clk);
    vtune <= 1'b0;
    cyc(3);
    chk("lock tune out", {31'h0, lockOut}, 32'h0);
    @(posedge core_clk);
    calBypass <= 1'b1;
    vtune <= 1'b1;
    cyc(3);
    chk("lock bypass", {31'h0, lockOut}, 32'h1);
    cal(1'b1);
    cyc(2);
    chk("lock bypass cal", {31'h0, lockOut}, 32'h1);
    $display("lock modes done");
    @(posedge core_clk);
    calBypass <= 1'b0;
    do_reset;
    // Pre-divide 2, multiply 6, post-divide 2: three detector events per two reference rises
    wr_reg(pdl_pkg::OFF_PREDIV, 32'h0000_0002);
    wr_reg(pdl_pkg::OFF_POSTDIV, 32'h0000_0002);
    wr_reg(pdl_pkg::OFF_LDLY, 32'h0000_0003);
    wr_reg(pdl_pkg::OFF_CTRL, 32'h0000_021A);
    cal(1'b1);
    cal(1'b0);
    tog(14);
    cyc(8);
    chk("ref_multiplier_factor early", {31'h0, lockOut}, 32'h0);
    tog(2);
    cyc(10);
    chk("ref_multiplier_factor late", {31'h0, lockOut}, 32'h1);
    $display("reference path done");
    do_reset;
    wr_reg(pdl_pkg::OFF_CTRL, 32'h0000_502C);
    @(posedge core_clk);
    refClk <= 1'b1;
    cyc(6);
    chk("pump dir", {30'h0, pumpUp, pumpDown}, 32'h1);
    chk("pump cur", {28'h0, pumpCurrent}, 32'h5);
    repeat (22) @(posedge core_clk) fbClk <= !fbClk;
    cyc(6);
    chk("pump held", {30'h0, pumpUp, pumpDown}, 32'h1);
    repeat (2) @(posedge core_clk) fbClk <= !fbClk;
    cyc(6);
    chk("pump clear", {30'h0, pumpUp, pumpDown}, 32'h0);
    $display("phase detector done");
    @(posedge core_clk);
    refClk <= 1'b0;
    do_reset;
    // Fraction 1/2 seeded with 1: first feedback count is 12 events, the second 13
    wr_reg(pdl_pkg::OFF_NUM, 32'h0000_0001);
    wr_reg(pdl_pkg::OFF_DEN, 32'h0000_0002);
    wr_reg(pdl_pkg::OFF_SEED, 32'h0000_0001);
    wr_reg(pdl_pkg::OFF_CTRL, 32'h0000_514C);
    cal(1'b1);
    @(posedge core_clk);
    refClk <= 1'b1;
    cyc(4);
    chk("frac up", {30'h0, pumpUp, pumpDown}, 32'h2);
    repeat (48) @(posedge core_clk) fbClk <= !fbClk;
    cyc(4);
    chk("frac first", {30'h0, pumpUp, pumpDown}, 32'h0);
    @(posedge core_clk);
    refClk <= 1'b0;
    @(posedge core_clk);
    refClk <= 1'b1;
    cyc(4);
    repeat (48) @(posedge core_clk) fbClk <= !fbClk;
    cyc(4);
    chk("frac carry", {30'h0, pumpUp, pumpDown}, 32'h2);
    repeat (4) @(posedge core_clk) fbClk <= !fbClk;
    cyc(4);
    chk("frac end", {30'h0, pumpUp, pumpDown}, 32'h0);
    $display("fraction done");
    stop_test;
  end
endmodule
`default_nettype wire

// ==== rtl/pdl_divider_lock.sv ====
// Reference path, feedback divider, phase detector and lock indicator
`timescale 1ns/1ps
`default_nettype none
module pdl_divider_lock (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire pdl_pkg::pdl_bus_t busReq,
  output logic [31:0] busRdata,
  // Analogue loop side
  input wire logic reference_clock_in,
  input wire logic fbClkIn,
  input wire logic calStart,
  input wire logic calDone,
  input wire logic calBypass,
  input wire logic vtuneInRange,
  // Charge pump and lock
  output logic pumpUp,
  output logic pumpDown,
  output logic [3:0] pumpCurrent,
  output logic lock_indicator
);

  pdl_pkg::pdl_state_t s;
  pdl_pkg::pdl_state_t n;

  logic refRise;
  logic refFall;
  logic dblPulse;
  logic prePulse;
  logic multUse;
  logic multPulse;
  logic fbEdge;
  logic fbEvent;
  logic fracOn;
  logic [32:0] sum;
  logic upNow;
  logic dnNow;
  logic calOk;
  logic lockNow;
  logic [17:0] ldTarget;
  logic [31:0] ctrlView;

  always_comb begin
    n = s;
    n.refPd = 1'b0;
    n.fbPd = 1'b0;
    n.rdData = '0;

    // Reference edges; the doubler takes both edges, so duty cycle sets its spurs
    refRise = reference_clock_in & ~s.refPrev;
    refFall = ~reference_clock_in & s.refPrev;
    n.refPrev = reference_clock_in;
    // Event rate is bounded by the core clock, far below the doubled limit
    dblPulse = s.dblEn ? (refRise | refFall) : refRise;

    // Pre-divider; ratio 0 behaves as 1
    prePulse = 1'b0;
    if (dblPulse) begin
      if (({1'b0, s.preCnt} + 13'h0001) >= {1'b0, s.preDiv}) begin
        n.preCnt = '0;
        prePulse = 1'b1;
      end else begin
        n.preCnt = s.preCnt + 12'h001;
      end
    end

    // Multiplier as an event credit; doubler wins if both are enabled
    multUse = s.multEn & ~s.dblEn;
    multPulse = multUse ? (s.credit != 8'h00) : prePulse;
    if (multUse) begin
      if (s.credit != 8'h00) begin
        n.credit = s.credit - 8'h01;
      end
      // Saturates instead of wrapping when input events outrun the core clock
      if (prePulse && (n.credit <= pdl_pkg::CREDIT_CAP)) begin
        n.credit = n.credit + {5'h00, s.multFactor};
      end
    end else begin
      n.credit = '0;
    end

    // Post-divider gives the phase detector reference event
    if (multPulse) begin
      if (({1'b0, s.postCnt} + 9'h001) >= {1'b0, s.postDiv}) begin
        n.postCnt = '0;
        n.refPd = 1'b1;
      end else begin
        n.postCnt = s.postCnt + 8'h01;
      end
    end

    // Feedback input with optional divide-by-two ahead of N
    fbEdge = fbClkIn & ~s.fbPrev;
    n.fbPrev = fbClkIn;
    fbEvent = fbEdge;
    if (s.extDiv2) begin
      fbEvent = fbEdge & s.fbHalf;
      if (fbEdge) begin
        n.fbHalf = ~s.fbHalf;
      end
    end else begin
      n.fbHalf = 1'b0;
    end

    // Integer plus fraction; zero denominator leaves the fraction off
    fracOn = (s.modOrder != pdl_pkg::ORD_INT) && (s.den != '0);
    sum = {1'b0, s.acc} + {1'b0, s.num};
    if (fbEvent) begin
      // Small N values are accepted; keeping the minimum is software's job
      if (({1'b0, s.nCnt} + 16'h0001) >= ({1'b0, s.nInt} + {15'h0000, s.extra})) begin
        n.nCnt = '0;
        n.fbPd = 1'b1;
        if (fracOn) begin
          if (sum >= {1'b0, s.den}) begin
            n.acc = 32'(sum - {1'b0, s.den});
            n.extra = 1'b1;
          end else begin
            n.acc = sum[31:0];
            n.extra = 1'b0;
          end
        end else begin
          n.acc = '0;
          n.extra = 1'b0;
        end
      end else begin
        n.nCnt = s.nCnt + 15'h0001;
      end
    end

    // Phase detector: each side holds until the other arrives
    upNow = s.upHeld | s.refPd;
    dnNow = s.dnHeld | s.fbPd;
    if (upNow & dnNow) begin
      upNow = 1'b0;
      dnNow = 1'b0;
    end
    n.upHeld = upNow;
    n.dnHeld = dnNow;
    n.pumpUp = s.pdPolInv ? dnNow : upNow;
    n.pumpDn = s.pdPolInv ? upNow : dnNow;
    n.pumpCur = (upNow | dnNow) ? s.cpCurrent : 4'h0;

    // Calibration tracking and lock delay
    ldTarget = {s.lockDly, pdl_pkg::LOCK_DELAY_COUNT_PAD};
    if (calStart) begin
      n.calActive = 1'b1;
      n.dlyDone = 1'b0;
      n.dlyCnt = '0;
      // Seed restarts the modulator phase, but never in integer mode
      n.acc = fracOn ? s.seed : 32'h0000_0000;
      n.extra = 1'b0;
    end else if (s.calActive) begin
      if (calDone) begin
        n.calActive = 1'b0;
      end
    end else if (!s.dlyDone) begin
      if (!s.vtLockEn || (s.dlyCnt >= ldTarget)) begin
        n.dlyDone = 1'b1;
      end else if (s.refPd) begin
        n.dlyCnt = s.dlyCnt + 18'h00001;
      end
    end

    calOk = ~s.calActive & s.dlyDone & ~calStart;
    if (calBypass) begin
      lockNow = vtuneInRange;
    end else if (s.vtLockEn) begin
      lockNow = calOk & vtuneInRange;
    end else begin
      lockNow = calOk;
    end
    n.lock = lockNow;

    // Register writes
    if (busReq.wr) begin
      case (busReq.addr)
        pdl_pkg::OFF_CTRL: begin
          n.dblEn = busReq.wdata[pdl_pkg::CB_DBL];
          n.multEn = busReq.wdata[pdl_pkg::CB_MEN];
          // Out-of-range factors are dropped and the old factor stays
          if ((busReq.wdata[pdl_pkg::CB_REF_MULTIPLIER_FACTOR +: 3] >= pdl_pkg::REF_MULTIPLIER_FACTOR_MIN) &&
              (busReq.wdata[pdl_pkg::CB_REF_MULTIPLIER_FACTOR +: 3] <= pdl_pkg::REF_MULTIPLIER_FACTOR_MAX)) begin
            n.multFactor = busReq.wdata[pdl_pkg::CB_REF_MULTIPLIER_FACTOR +: 3];
          end
          n.pdPolInv = busReq.wdata[pdl_pkg::CB_POL];
          n.modOrder = busReq.wdata[pdl_pkg::CB_ORD +: 2];
          n.extDiv2 = busReq.wdata[pdl_pkg::CB_XDIV];
          n.vtLockEn = busReq.wdata[pdl_pkg::CB_VTEN];
          n.cpCurrent = busReq.wdata[pdl_pkg::CB_CP +: 4];
        end
        pdl_pkg::OFF_PREDIV: begin
          n.preDiv = busReq.wdata[11:0];
        end
        pdl_pkg::OFF_POSTDIV: begin
          n.postDiv = busReq.wdata[7:0];
        end
        pdl_pkg::OFF_NINT: begin
          n.nInt = busReq.wdata[14:0];
        end
        pdl_pkg::OFF_NUM: begin
          n.num = busReq.wdata;
        end
        pdl_pkg::OFF_DEN: begin
          n.den = busReq.wdata;
        end
        pdl_pkg::OFF_SEED: begin
          n.seed = busReq.wdata;
        end
        pdl_pkg::OFF_LDLY: begin
          n.lockDly = busReq.wdata[15:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered in the next cycle only
    ctrlView = '0;
    ctrlView[pdl_pkg::CB_DBL] = s.dblEn;
    ctrlView[pdl_pkg::CB_MEN] = s.multEn;
    ctrlView[pdl_pkg::CB_REF_MULTIPLIER_FACTOR +: 3] = s.multFactor;
    ctrlView[pdl_pkg::CB_POL] = s.pdPolInv;
    ctrlView[pdl_pkg::CB_ORD +: 2] = s.modOrder;
    ctrlView[pdl_pkg::CB_XDIV] = s.extDiv2;
    ctrlView[pdl_pkg::CB_VTEN] = s.vtLockEn;
    ctrlView[pdl_pkg::CB_CP +: 4] = s.cpCurrent;
    if (busReq.rd) begin
      case (busReq.addr)
        pdl_pkg::OFF_CTRL: begin
          n.rdData = ctrlView;
        end
        pdl_pkg::OFF_PREDIV: begin
          n.rdData = {20'h00000, s.preDiv};
        end
        pdl_pkg::OFF_POSTDIV: begin
          n.rdData = {24'h000000, s.postDiv};
        end
        pdl_pkg::OFF_NINT: begin
          n.rdData = {17'h00000, s.nInt};
        end
        pdl_pkg::OFF_NUM: begin
          n.rdData = s.num;
        end
        pdl_pkg::OFF_DEN: begin
          n.rdData = s.den;
        end
        pdl_pkg::OFF_SEED: begin
          n.rdData = s.seed;
        end
        pdl_pkg::OFF_LDLY: begin
          n.rdData = {16'h0000, s.lockDly};
        end
        pdl_pkg::OFF_STATUS: begin
          n.rdData[pdl_pkg::SB_LOCK] = s.lock;
          n.rdData[pdl_pkg::SB_CAL] = s.calActive;
          n.rdData[pdl_pkg::SB_DLY] = s.dlyDone;
          n.rdData[pdl_pkg::SB_FRAC] = fracOn;
        end
        default: begin
          n.rdData = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= pdl_pkg::STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign busRdata = s.rdData;
  assign pumpUp = s.pumpUp;
  assign pumpDown = s.pumpDn;
  assign pumpCurrent = s.pumpCur;
  assign lock_indicator = s.lock;

endmodule
`default_nettype wire

// ==== rtl/pdl_pkg.sv ====
// Constants, register map and state type for the divider path and lock detect block
// Contract
// - Doubler gives two output events per reference period, rate kept under 500 MHz.
// - Doubler reacts to every rising and every falling reference edge.
// - Multiplier accepts only factors 3, 4, 5, 6 and 7.
// - Pre-divider lowers the reference ahead of multiplier and post-divider.
// - Phase detector compares both divider outputs, drives programmed current until aligned.
// - Phase detector polarity is selectable for inverting loop filters.
// - Feedback ratio is integer part plus numerator over denominator.
// - Denominator is a 32-bit field accepting 1 up to 2^32-1.
// - Order 0 applies no phase shift from the seed value.
// - Order field takes 0 to 3; 0 is pure integer division.
// - Lock goes low when calibration starts, stays low while calibrating.
// - With tuning lock enabled, lock waits four times delay count in detector cycles.
// - Tuning lock goes low when mimicked tuning voltage leaves its range.
// - Calibration and tuning conditions can combine into one lock indication.
// - With calibration bypassed, lock reflects only the tuning condition.
package pdl_pkg;
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PREDIV = 8'h04;
  localparam logic [7:0] OFF_POSTDIV = 8'h08;
  localparam logic [7:0] OFF_NINT = 8'h0C;
  localparam logic [7:0] OFF_NUM = 8'h10;
  localparam logic [7:0] OFF_DEN = 8'h14;
  localparam logic [7:0] OFF_SEED = 8'h18;
  localparam logic [7:0] OFF_LDLY = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  // Control field positions
  localparam int CB_DBL = 0;
  localparam int CB_MEN = 1;
  localparam int CB_REF_MULTIPLIER_FACTOR = 2;
  localparam int CB_POL = 5;
  localparam int CB_ORD = 6;
  localparam int CB_XDIV = 8;
  localparam int CB_VTEN = 9;
  localparam int CB_CP = 12;
  // Status field positions
  localparam int SB_LOCK = 0;
  localparam int SB_CAL = 1;
  localparam int SB_DLY = 2;
  localparam int SB_FRAC = 3;
  // Limits and reset values
  localparam int DOUBLER_MAX_MHZ = 500;
  localparam int CORE_MHZ = 20;
  localparam logic [2:0] REF_MULTIPLIER_FACTOR_MIN = 3'h3;
  localparam logic [2:0] REF_MULTIPLIER_FACTOR_MAX = 3'h7;
  localparam logic [1:0] ORD_INT = 2'h0;
  localparam logic [1:0] LOCK_DELAY_COUNT_PAD = 2'h0;
  localparam logic [7:0] CREDIT_CAP = 8'hF0;
  localparam logic [11:0] PREDIV_RST = 12'h001;
  localparam logic [7:0] POSTDIV_RST = 8'h01;
  localparam logic [14:0] NINT_RST = 15'h000C;
  localparam logic [31:0] DEN_RST = 32'h0000_0001;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pdl_bus_t;

  typedef struct packed {
    logic dblEn, multEn, pdPolInv, extDiv2, vtLockEn;
    logic [2:0] multFactor;
    logic [1:0] modOrder;
    logic [3:0] cpCurrent;
    logic [11:0] preDiv, preCnt;
    logic [7:0] postDiv, postCnt, credit;
    logic [14:0] nInt, nCnt;
    logic [31:0] num, den, seed, acc, rdData;
    logic [15:0] lockDly;
    logic [17:0] dlyCnt;
    logic refPrev, fbPrev, fbHalf, extra, refPd, fbPd;
    logic upHeld, dnHeld, calActive, dlyDone;
    logic pumpUp, pumpDn, lock;
    logic [3:0] pumpCur;
  } pdl_state_t;

  localparam pdl_state_t STATE_RST = '{multFactor: REF_MULTIPLIER_FACTOR_MIN, preDiv: PREDIV_RST,
    postDiv: POSTDIV_RST, nInt: NINT_RST, den: DEN_RST, default: '0};
endpackage
